/* File: hw/crxo_pkg.sv */
// constants for the can receive object and interrupt block
`default_nettype none
package crxo_pkg;
	// ==========================
	// sizes
	localparam int NOBJ = 32;
	// ==========================
	// register offsets
	localparam logic [7:0] A_CTL  = 8'h00;
	localparam logic [7:0] A_STS  = 8'h04;
	localparam logic [7:0] A_INT  = 8'h08;
	localparam logic [7:0] A_CMSK = 8'h0c;
	localparam logic [7:0] A_CRQ  = 8'h10;
	localparam logic [7:0] A_MSK1 = 8'h14;
	localparam logic [7:0] A_MSK2 = 8'h18;
	localparam logic [7:0] A_ARB1 = 8'h1c;
	localparam logic [7:0] A_ARB2 = 8'h20;
	localparam logic [7:0] A_MCTL = 8'h24;
	localparam logic [7:0] A_DA1  = 8'h28;
	localparam logic [7:0] A_DA2  = 8'h2c;
	localparam logic [7:0] A_DB1  = 8'h30;
	localparam logic [7:0] A_DB2  = 8'h34;
	localparam logic [7:0] A_PND1 = 8'h38;
	localparam logic [7:0] A_PND2 = 8'h3c;
	// ==========================
	// control register bits
	localparam int CTL_IE  = 1;
	localparam int CTL_SIE = 2;
	localparam int CTL_EIE = 3;
	localparam logic [15:0] CTL_RST = 16'h0000;
	// ==========================
	// command mask bits
	localparam int CM_WR  = 7;
	localparam int CM_MSK = 6;
	localparam int CM_ARB = 5;
	localparam int CM_CTL = 4;
	localparam int CM_CIP = 3;
	localparam int CM_NDT = 2;
	localparam int CM_DA  = 1;
	localparam int CM_DB  = 0;
	localparam logic [7:0] CMSK_RST = 8'h00;
	// ==========================
	// message control bits
	localparam int MC_NDT  = 15;
	localparam int MC_LST  = 14;
	localparam int MC_IP   = 13;
	localparam int MC_UM   = 12;
	localparam int MC_TX_IRQ_ENABLE = 11;
	localparam int MC_RX_IRQ_ENABLE = 10;
	localparam int MC_RMT  = 9;
	localparam int MC_TRQ  = 8;
	localparam int MC_EOB  = 7;
	// ==========================
	// arbitration and status layout
	localparam int AR_VAL  = 15;
	localparam int AR_XTD  = 14;
	localparam int AR_DIR  = 13;
	localparam int MK_XTD  = 15;
	localparam int STD_LSB = 18;
	localparam logic [15:0] STS_INT_ID = 16'h8000;
	localparam logic [4:0]  STS_RST    = 5'h00;
endpackage
`default_nettype wire

/* File: hw/crxo_top.sv */
// receive objects, interface buffers and interrupt priority of a can controller
//
// Design decisions made here: the register addresses and strobed register access.
`default_nettype none
module crxo_top
	import crxo_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	output logic      [15:0] rdata,
	input  wire logic        rx_valid,
	input  wire logic        rx_rtr,
	input  wire logic        rx_xtd,
	input  wire logic [28:0] rx_id,
	input  wire logic [3:0]  rx_dlc,
	input  wire logic [63:0] rx_data,
	input  wire logic        sts_upd,
	input  wire logic        sts_receive_ok_flag,
	input  wire logic        sts_transmit_ok_flag,
	input  wire logic [2:0]  sts_lec,
	output logic             rtr_req,
	output logic             rtr_xtd,
	output logic      [28:0] rtr_id,
	input  wire logic        rtr_done,
	output logic             irq
);
	// ==========================
	// lowest set bit search, object 1 wins
	function automatic logic [5:0] crxo_first(input logic [31:0] v);
		logic [5:0] r;
		r = 6'h00;
		for (int i = NOBJ - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, 5'(i)};
			end
		end
		return r;
	endfunction

	// ==========================
	// message ram, flip-flops indexed by object
	logic [28:0] id_q   [NOBJ]; // arbitration tag
	logic [28:0] msk_q  [NOBJ]; // acceptance mask
	logic [3:0]  dlc_q  [NOBJ]; // length code
	logic [63:0] data_q [NOBJ]; // data bytes
	logic [31:0] val_q;         // object valid
	logic [31:0] xtd_q;         // extended id
	logic [31:0] dir_q;         // direction, one is transmit
	logic [31:0] mxtd_q;        // extended-only mask
	logic [31:0] use_acceptance_mask_q;       // use acceptance mask
	logic [31:0] tx_irq_enable_q;        // tx irq enable
	logic [31:0] rx_irq_enable_q;        // rx irq enable
	logic [31:0] remote_answer_enable_q;       // remote answer enable
	logic [31:0] eob_q;         // end of buffer
	logic [31:0] new_data_flag_q;      // new data flag
	logic [31:0] message_overrun_flag_q;      // message overrun flag
	logic [31:0] interrupt_pending_flag_q;      // interrupt pending flag
	logic [31:0] transmit_request_flag_q;      // transmit request flag

	// ==========================
	// interface buffers and control
	logic [15:0] if_msk1_q;     // mask low word
	logic [15:0] if_msk2_q;     // mask high word
	logic [15:0] if_arb1_q;     // arbitration low word
	logic [15:0] if_arb2_q;     // arbitration high word
	logic [15:0] if_mctl_q;     // message control
	logic [63:0] if_data_q;     // data buffer
	logic [7:0]  cmsk_q;        // command mask
	logic [15:0] ctl_q;         // controller control
	logic [4:0]  sts_q;         // receive_ok_flag, transmit_ok_flag, lec
	logic        sts_int_q;     // status interrupt source
	logic [15:0] rdata_q;       // read data
	logic        irq_q;         // interrupt line
	logic        rtr_req_q;     // remote frame wanted
	logic [4:0]  rtr_obj_q;     // object of remote frame
	logic        rtr_xtd_q;     // remote frame id type
	logic [28:0] rtr_id_q;      // remote frame id

	// ==========================
	// acceptance match, one comparator per object
	logic [31:0] hit;
	for (genvar g = 0; g < NOBJ; g++) begin : g_match
		logic [28:0] cm;
		logic [28:0] cmp;
		logic        xtd_ok;
		assign cm     = use_acceptance_mask_q[g] ? msk_q[g] : {29{1'b1}};
		assign cmp    = rx_xtd ? cm : {cm[28:STD_LSB], 18'h00000};
		assign xtd_ok = (use_acceptance_mask_q[g] && mxtd_q[g]) ? rx_xtd
			: (use_acceptance_mask_q[g] || (xtd_q[g] == rx_xtd));
		assign hit[g] = val_q[g] && (dir_q[g] == rx_rtr) && xtd_ok
			&& (((id_q[g] ^ rx_id) & cmp) == 29'h0);
	end

	// ==========================
	// frame and command decode
	logic [5:0]  hsel;
	logic        store;
	logic        rmt;
	logic        xfer;
	logic        xfer_wr;
	logic        xfer_rd;
	logic [4:0]  xobj;
	logic [5:0]  psel;
	logic [15:0] interrupt_source_index;
	assign hsel    = crxo_first(hit);
	assign store   = rx_valid && hsel[5] && !rx_rtr;
	assign rmt     = rx_valid && hsel[5] && rx_rtr && remote_answer_enable_q[hsel[4:0]];
	// object numbers 1..32 map to index 0..31, others ignored
	assign xfer    = wr_en && (addr == A_CRQ) && (wdata[5:0] != 6'h00)
		&& (wdata[15:0] <= 16'(NOBJ));
	assign xobj    = 5'(wdata[5:0] - 6'h01);
	assign xfer_wr = xfer && cmsk_q[CM_WR];
	assign xfer_rd = xfer && !cmsk_q[CM_WR];
	assign psel    = crxo_first(interrupt_pending_flag_q);
	logic [5:0]  rsel; // lowest receive object asking for a remote frame
	assign rsel    = crxo_first(val_q & ~dir_q & transmit_request_flag_q);
	// ==========================
	// interrupt identifier, status first then lowest object
	always_comb begin
		if (sts_int_q) begin
			interrupt_source_index = STS_INT_ID;
		end else if (psel[5]) begin
			interrupt_source_index = 16'({1'b0, psel[4:0]} + 6'h01);
		end else begin
			interrupt_source_index = 16'h0000;
		end
	end

	// ==========================
	// object contents, no reset needed
	always_ff @(posedge clk) begin
		for (int i = 0; i < NOBJ; i++) begin
			// cpu write transfer from buffers
			if (xfer_wr && xobj == 5'(i)) begin
				if (cmsk_q[CM_MSK]) msk_q[i] <= {if_msk2_q[12:0], if_msk1_q};
				if (cmsk_q[CM_ARB]) id_q[i] <= {if_arb2_q[12:0], if_arb1_q};
				if (cmsk_q[CM_CTL]) dlc_q[i] <= if_mctl_q[3:0];
				if (cmsk_q[CM_DA]) data_q[i][31:0] <= if_data_q[31:0];
				if (cmsk_q[CM_DB]) data_q[i][63:32] <= if_data_q[63:32];
			end
			// received data frame wins over a write transfer
			if (store && hsel[4:0] == 5'(i)) begin
				id_q[i]   <= rx_xtd ? rx_id : {rx_id[28:STD_LSB], 18'h00000};
				dlc_q[i]  <= rx_dlc;
				data_q[i] <= rx_data;
			end
		end
	end
	// ==========================
	// object configuration and flags
	always_ff @(posedge clk) begin
		if (rst) begin
			val_q    <= 32'h0;
			xtd_q    <= 32'h0;
			dir_q    <= 32'h0;
			mxtd_q   <= 32'h0;
			use_acceptance_mask_q  <= 32'h0;
			tx_irq_enable_q   <= 32'h0;
			rx_irq_enable_q   <= 32'h0;
			remote_answer_enable_q  <= 32'h0;
			eob_q    <= 32'h0;
			new_data_flag_q <= 32'h0;
			message_overrun_flag_q <= 32'h0;
			interrupt_pending_flag_q <= 32'h0;
			transmit_request_flag_q <= 32'h0;
		end else begin
			for (int i = 0; i < NOBJ; i++) begin
				// remote frame went out; a new cpu request below wins
				if (rtr_done && rtr_req_q && rtr_obj_q == 5'(i)) transmit_request_flag_q[i] <= 1'b0;
				if (xfer_wr && xobj == 5'(i)) begin
					// write transfer
					if (cmsk_q[CM_ARB]) begin
						val_q[i] <= if_arb2_q[AR_VAL];
						xtd_q[i] <= if_arb2_q[AR_XTD];
						dir_q[i] <= if_arb2_q[AR_DIR];
					end
					if (cmsk_q[CM_MSK]) mxtd_q[i] <= if_msk2_q[MK_XTD];
					if (cmsk_q[CM_CTL]) begin
						new_data_flag_q[i] <= if_mctl_q[MC_NDT];
						message_overrun_flag_q[i] <= if_mctl_q[MC_LST];
						interrupt_pending_flag_q[i] <= if_mctl_q[MC_IP];
						use_acceptance_mask_q[i]  <= if_mctl_q[MC_UM];
						tx_irq_enable_q[i]   <= if_mctl_q[MC_TX_IRQ_ENABLE];
						rx_irq_enable_q[i]   <= if_mctl_q[MC_RX_IRQ_ENABLE];
						remote_answer_enable_q[i]  <= if_mctl_q[MC_RMT];
						transmit_request_flag_q[i] <= if_mctl_q[MC_TRQ];
						eob_q[i]    <= if_mctl_q[MC_EOB];
					end
					if (cmsk_q[CM_NDT]) transmit_request_flag_q[i] <= 1'b1;
				end else if (xfer_rd && xobj == 5'(i)) begin
					// read transfer acknowledges the object
					if (cmsk_q[CM_NDT]) new_data_flag_q[i] <= 1'b0;
					if (cmsk_q[CM_CIP]) interrupt_pending_flag_q[i] <= 1'b0;
				end
				// remote request received for a transmit object
				if (rmt && hsel[4:0] == 5'(i)) transmit_request_flag_q[i] <= 1'b1;
				// data frame stored, its sets win over cpu clears and its transmit request clear wins over a cpu set
				if (store && hsel[4:0] == 5'(i)) begin
					new_data_flag_q[i] <= 1'b1;
					message_overrun_flag_q[i] <= message_overrun_flag_q[i] | (new_data_flag_q[i]
						& !(xfer_rd && xobj == 5'(i) && cmsk_q[CM_NDT]));
					if (rx_irq_enable_q[i]) interrupt_pending_flag_q[i] <= 1'b1;
					transmit_request_flag_q[i] <= 1'b0;
				end
			end
		end
	end
	// ==========================
	// interface buffers, cpu writes and read transfers
	always_ff @(posedge clk) begin
		if (rst) begin
			if_msk1_q <= 16'h0000;
			if_msk2_q <= 16'h0000;
			if_arb1_q <= 16'h0000;
			if_arb2_q <= 16'h0000;
			if_mctl_q <= 16'h0000;
			if_data_q <= 64'h0;
		end else if (xfer_rd) begin
			// snapshot of the old object's fields selected by the command mask in one edge
			if (cmsk_q[CM_MSK]) begin
				if_msk1_q <= msk_q[xobj][15:0];
				if_msk2_q <= {mxtd_q[xobj], 2'b00, msk_q[xobj][28:16]};
			end
			if (cmsk_q[CM_ARB]) begin
				if_arb1_q <= id_q[xobj][15:0];
				if_arb2_q <= {val_q[xobj], xtd_q[xobj], dir_q[xobj],
					id_q[xobj][28:16]};
			end
			if (cmsk_q[CM_CTL]) begin
				if_mctl_q <= {new_data_flag_q[xobj], message_overrun_flag_q[xobj], interrupt_pending_flag_q[xobj],
					use_acceptance_mask_q[xobj], tx_irq_enable_q[xobj], rx_irq_enable_q[xobj], remote_answer_enable_q[xobj],
					transmit_request_flag_q[xobj], eob_q[xobj], 3'b000, dlc_q[xobj]};
			end
			if (cmsk_q[CM_DA]) if_data_q[31:0] <= data_q[xobj][31:0];
			if (cmsk_q[CM_DB]) if_data_q[63:32] <= data_q[xobj][63:32];
		end else if (wr_en) begin
			if (addr == A_MSK1) begin
				if_msk1_q <= wdata;
			end else if (addr == A_MSK2) begin
				if_msk2_q <= wdata;
			end else if (addr == A_ARB1) begin
				if_arb1_q <= wdata;
			end else if (addr == A_ARB2) begin
				if_arb2_q <= wdata;
			end else if (addr == A_MCTL) begin
				if_mctl_q <= wdata;
			end else if (addr == A_DA1) begin
				if_data_q[15:0] <= wdata;
			end else if (addr == A_DA2) begin
				if_data_q[31:16] <= wdata;
			end else if (addr == A_DB1) begin
				if_data_q[47:32] <= wdata;
			end else if (addr == A_DB2) begin
				if_data_q[63:48] <= wdata;
			end
		end
	end

	// ==========================
	// control and command mask registers
	always_ff @(posedge clk) begin
		if (rst) begin
			ctl_q  <= CTL_RST;
			cmsk_q <= CMSK_RST;
		end else if (wr_en) begin
			if (addr == A_CTL) begin
				ctl_q <= wdata;
			end else if (addr == A_CMSK) begin
				cmsk_q <= wdata[7:0];
			end
		end
	end

	// ==========================
	// status register and status interrupt source
	always_ff @(posedge clk) begin
		if (rst) begin
			sts_q     <= STS_RST;
			sts_int_q <= 1'b0;
		end else begin
			// cpu write loads fields, core update wins
			if (sts_upd) begin
				sts_q <= {sts_receive_ok_flag, sts_transmit_ok_flag, sts_lec};
			end else if (wr_en && addr == A_STS) begin
				sts_q <= wdata[4:0];
			end
			// only a status read clears the source, a new update wins
			if (sts_upd && (ctl_q[CTL_SIE]
				|| (ctl_q[CTL_EIE] && sts_lec != 3'h0))) begin
				sts_int_q <= 1'b1;
			end else if (rd_en && addr == A_STS) begin
				sts_int_q <= 1'b0;
			end
		end
	end

	// ==========================
	// read data, one cycle after the strobe
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_q <= 16'h0000;
		end else if (rd_en) begin
			if (addr == A_CTL) begin
				rdata_q <= ctl_q;
			end else if (addr == A_STS) begin
				rdata_q <= {11'h000, sts_q};
			end else if (addr == A_INT) begin
				rdata_q <= interrupt_source_index;
			end else if (addr == A_CMSK) begin
				rdata_q <= {8'h00, cmsk_q};
			end else if (addr == A_MSK1) begin
				rdata_q <= if_msk1_q;
			end else if (addr == A_MSK2) begin
				rdata_q <= if_msk2_q;
			end else if (addr == A_ARB1) begin
				rdata_q <= if_arb1_q;
			end else if (addr == A_ARB2) begin
				rdata_q <= if_arb2_q;
			end else if (addr == A_MCTL) begin
				rdata_q <= if_mctl_q;
			end else if (addr == A_DA1) begin
				rdata_q <= if_data_q[15:0];
			end else if (addr == A_DA2) begin
				rdata_q <= if_data_q[31:16];
			end else if (addr == A_DB1) begin
				rdata_q <= if_data_q[47:32];
			end else if (addr == A_DB2) begin
				rdata_q <= if_data_q[63:48];
			end else if (addr == A_PND1) begin
				rdata_q <= interrupt_pending_flag_q[15:0];
			end else if (addr == A_PND2) begin
				rdata_q <= interrupt_pending_flag_q[31:16];
			end else begin
				// unmapped and write-only offsets read zero
				rdata_q <= 16'h0000;
			end
		end else begin
			rdata_q <= 16'h0000;
		end
	end

	// ==========================
	// interrupt line
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= ctl_q[CTL_IE] && (interrupt_source_index != 16'h0000);
		end
	end

	// ==========================
	// remote frame request for receive objects
	always_ff @(posedge clk) begin
		if (rst) begin
			rtr_req_q <= 1'b0;
			rtr_obj_q <= 5'h00;
			rtr_xtd_q <= 1'b0;
			rtr_id_q  <= 29'h0;
		end else begin
			rtr_req_q <= rsel[5];
			rtr_obj_q <= rsel[4:0];
			rtr_xtd_q <= xtd_q[rsel[4:0]];
			rtr_id_q  <= id_q[rsel[4:0]];
		end
	end
	assign rdata   = rdata_q;
	assign irq     = irq_q;
	assign rtr_req = rtr_req_q;
	assign rtr_xtd = rtr_xtd_q;
	assign rtr_id  = rtr_id_q;
endmodule // crxo_top
`default_nettype wire

/* File: tb/crxo_core_model.sv */
// behavioural can core feeding frames and status to the rx object block
`default_nettype none
module crxo_core_model (
	input  wire logic        clk,
	input  wire logic        rtr_req,
	input  wire logic [7:0]  rtr_wait,
	output logic             rx_valid,
	output logic             rx_rtr,
	output logic             rx_xtd,
	output logic      [28:0] rx_id,
	output logic      [3:0]  rx_dlc,
	output logic      [63:0] rx_data,
	output logic             sts_upd,
	output logic             sts_receive_ok_flag,
	output logic             sts_transmit_ok_flag,
	output logic      [2:0]  sts_lec,
	output logic             rtr_done
);
	timeunit 1ns;
	timeprecision 1ps;
	int n = 0; // cycles the current remote request has waited
	initial begin
		{rx_valid, rx_rtr, rx_xtd, rx_id, rx_dlc, rx_data} = '0;
		{sts_upd, sts_receive_ok_flag, sts_transmit_ok_flag, sts_lec, rtr_done} = '0;
	end
	// ==========
	// answer a remote request once it has waited rtr_wait cycles
	always @(posedge clk) begin
		rtr_done <= 1'b0;
		n <= rtr_req ? n + 1 : 0;
		if (rtr_req && n == int'(rtr_wait)) begin
			rtr_done <= 1'b1;
		end
	end
	// one received frame; lines are scrambled outside the pulse
	task automatic frame(input logic [28:0] id, input logic [63:0] d, input logic x = 1'b0);
		@(posedge clk);
		rx_valid <= 1'b1;
		rx_xtd <= x;
		rx_id <= id;
		rx_dlc <= 4'h8;
		rx_data <= d;
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_xtd <= ~x;
		rx_id <= ~id;
		rx_data <= ~d;
	endtask
	// one status update pulse
	task automatic status(input logic [4:0] v);
		@(posedge clk);
		sts_upd <= 1'b1;
		{sts_receive_ok_flag, sts_transmit_ok_flag, sts_lec} <= v;
		@(posedge clk);
		sts_upd <= 1'b0;
	endtask
endmodule // crxo_core_model
`default_nettype wire

/* File: tb/crxo_top_props.sv */
// port-level assertions for the rx object block
`default_nettype none
module crxo_top_chk
	import crxo_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [7:0]  addr,
	input wire logic [15:0] wdata,
	input wire logic        wr_en,
	input wire logic        rd_en,
	input wire logic [15:0] rdata,
	input wire logic        rx_valid,
	input wire logic        rx_rtr,
	input wire logic        rx_xtd,
	input wire logic [28:0] rx_id,
	input wire logic [3:0]  rx_dlc,
	input wire logic [63:0] rx_data,
	input wire logic        sts_upd,
	input wire logic        sts_receive_ok_flag,
	input wire logic        sts_transmit_ok_flag,
	input wire logic [2:0]  sts_lec,
	input wire logic        rtr_req,
	input wire logic        rtr_xtd,
	input wire logic [28:0] rtr_id,
	input wire logic        rtr_done,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic [15:0] ctl_q;  // mirror of the control register
	logic        stat_q; // mirror of the status interrupt source
	logic        rd_int; // read of the identifier this cycle
	assign rd_int = rd_en && addr == A_INT;
	// ==========
	// helper mirrors
	always_ff @(posedge clk) begin
		if (rst) begin
			ctl_q <= CTL_RST;
		end else if (wr_en && addr == A_CTL) begin
			ctl_q <= wdata;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			stat_q <= 1'b0;
		end else if (sts_upd && (ctl_q[CTL_SIE] || (ctl_q[CTL_EIE] && sts_lec != 3'h0))) begin
			stat_q <= 1'b1;
		end else if (rd_en && addr == A_STS) begin
			stat_q <= 1'b0;
		end
	end
	// ==========
	// properties
	property p_irq_line;
		$past(rd_int) |-> irq == ($past(ctl_q[CTL_IE]) && rdata != 16'h0000);
	endproperty
	a_irq_line: assert property (p_irq_line) else $error("irq differs from ie and id");
	property p_irq_off;
		!ctl_q[CTL_IE] && !$past(ctl_q[CTL_IE]) |-> !irq;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
	property p_irq_rise;
		$rose(irq) |-> $past(ctl_q[CTL_IE]);
	endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("irq rose without enable");
	property p_sts_id;
		rd_int |=> (rdata == STS_INT_ID) == $past(stat_q);
	endproperty
	a_sts_id: assert property (p_sts_id) else $error("status id mismatch");
	property p_sts_first;
		rd_int && stat_q |=> rdata == STS_INT_ID;
	endproperty
	a_sts_first: assert property (p_sts_first) else $error("status not first");
	property p_int_range;
		rd_int |=> rdata == STS_INT_ID || rdata <= 16'h0020;
	endproperty
	a_int_range: assert property (p_int_range) else $error("id out of range");
	property p_rd_zero;
		!$past(rd_en) |-> rdata == 16'h0000;
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("rdata not idle");
	property p_rtr_done;
		rtr_req && rtr_done |-> ##2 !rtr_req;
	endproperty
	a_rtr_done: assert property (p_rtr_done) else $error("remote request kept");
endmodule // crxo_top_chk
bind crxo_top crxo_top_chk u_chk (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
	.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rx_valid(rx_valid), .rx_rtr(rx_rtr),
	.rx_xtd(rx_xtd), .rx_id(rx_id), .rx_dlc(rx_dlc), .rx_data(rx_data), .sts_upd(sts_upd),
	.sts_receive_ok_flag(sts_receive_ok_flag), .sts_transmit_ok_flag(sts_transmit_ok_flag), .sts_lec(sts_lec), .rtr_req(rtr_req),
	.rtr_xtd(rtr_xtd), .rtr_id(rtr_id), .rtr_done(rtr_done), .irq(irq));
`default_nettype wire

/* File: tb/test_crxo_top.sv */
// self-checking bench for the rx object block
`default_nettype none
module test_crxo_top
	import crxo_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1, wr_en = 0, rd_en = 0, rd_seen = 0;
	logic rx_valid, rx_rtr, rx_xtd, sts_upd, sts_receive_ok_flag, sts_transmit_ok_flag, rtr_req, rtr_xtd, rtr_done, irq;
	logic [7:0] addr = '0, rtr_wait = 8'h03;
	logic [15:0] wdata = '0, rdata;
	logic [28:0] rx_id, rtr_id;
	logic [3:0] rx_dlc;
	logic [2:0] sts_lec;
	logic [63:0] rx_data, d3;
	logic [15:0] q[$]; // expected read data, oldest first
	int n_fail = 0, cmp_count = 0, seed = 58;
	initial forever #4 clk = ~clk;
	crxo_top dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .rx_valid(rx_valid), .rx_rtr(rx_rtr), .rx_xtd(rx_xtd),
		.rx_id(rx_id), .rx_dlc(rx_dlc), .rx_data(rx_data), .sts_upd(sts_upd),
		.sts_receive_ok_flag(sts_receive_ok_flag), .sts_transmit_ok_flag(sts_transmit_ok_flag), .sts_lec(sts_lec), .rtr_req(rtr_req),
		.rtr_xtd(rtr_xtd), .rtr_id(rtr_id), .rtr_done(rtr_done), .irq(irq));
	crxo_core_model core (.clk(clk), .rtr_req(rtr_req), .rtr_wait(rtr_wait),
		.rx_valid(rx_valid), .rx_rtr(rx_rtr), .rx_xtd(rx_xtd), .rx_id(rx_id), .rx_dlc(rx_dlc),
		.rx_data(rx_data), .sts_upd(sts_upd), .sts_receive_ok_flag(sts_receive_ok_flag), .sts_transmit_ok_flag(sts_transmit_ok_flag),
		.sts_lec(sts_lec), .rtr_done(rtr_done));
	// ==========
	// compare and report
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic conclude;
		$display("mismatches %0d compares %0d", n_fail, cmp_count);
		if (n_fail == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// read data monitor: oldest note against the answer
	always @(posedge clk) begin
		if (rd_seen) chk(rdata, q.pop_front());
		rd_seen <= rd_en;
	end
	initial begin
		repeat (100000) @(posedge clk);
		n_fail++;
		conclude();
	end
	// ==========
	// bus tasks
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		q.push_back(e);
		@(posedge clk);
		rd_en <= 1'b0;
	endtask
	task automatic xfer(input logic [15:0] m, input logic [15:0] n);
		wr(A_CMSK, m);
		wr(A_CRQ, n);
	endtask
	// write mask, arbitration and control into one object
	task automatic cfg(input logic [15:0] n, a2, m2, mc);
		wr(A_MSK1, 16'h0000);
		wr(A_MSK2, m2);
		wr(A_ARB1, 16'h0000);
		wr(A_ARB2, a2);
		wr(A_MCTL, mc);
		xfer(16'h00f0, n);
	endtask
	task automatic wait_rtr(input logic v);
		int i;
		for (i = 0; i < 300 && rtr_req !== v; i++) @(posedge clk);
		if (i == 300) begin
			n_fail++;
			conclude();
		end
	endtask
	// ==========
	// main sequence
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		cfg(3, 16'h848c, 16'h0000, 16'h0488);
		cfg(2, 16'h8294, 16'h0000, 16'h0488);
		wr(A_CTL, 16'h0002);
		core.frame({11'h123, 18'h0}, {$random(seed), $random(seed)});
		rd(A_INT, 16'h0003);
		core.frame({11'h0a5, 18'h0}, {$random(seed), $random(seed)});
		rd(A_INT, 16'h0002);
		rd(A_PND1, 16'h0006);
		d3 = {$random(seed), $random(seed)};
		core.frame({11'h123, 18'h0}, d3);
		xfer(16'h007f, 3);
		rd(A_ARB2, 16'h848c);
		rd(A_ARB1, 16'h0000);
		rd(A_MCTL, 16'he488);
		for (int k = 0; k < 4; k++) rd(A_DA1 + 8'(4 * k), d3[16 * k +: 16]);
		rd(A_INT, 16'h0002);
		xfer(16'h007f, 3);
		rd(A_MCTL, 16'h4488);
		chk(16'(irq), 16'h0001);
		xfer(16'h007f, 2);
		rd(A_INT, 16'h0000);
		// status source against a pending object
		wr(A_CTL, 16'h0006);
		core.status(5'h13);
		core.frame({11'h0a5, 18'h0}, d3);
		rd(A_INT, STS_INT_ID);
		rd(A_STS, 16'h0013);
		rd(A_INT, 16'h0002);
		wr(A_STS, 16'h0000);
		rd(A_STS, 16'h0000);
		wr(A_CTL, 16'h0002);
		core.status(5'h05);
		rd(A_INT, 16'h0002);
		wr(A_CTL, 16'h000a);
		core.status(5'h05);
		rd(A_INT, STS_INT_ID);
		rd(A_STS, 16'h0005);
		wr(A_CTL, 16'h0000);
		xfer(16'h007f, 2);
		core.frame({11'h123, 18'h0}, d3);
		rd(A_INT, 16'h0003);
		chk(16'(irq), 16'h0000);
		xfer(16'h007f, 3);
		// remote request answered, then overtaken by data
		cfg(5, 16'h8c84, 16'h0000, 16'h0088);
		xfer(16'h0084, 5);
		wait_rtr(1'b1);
		chk(16'(rtr_id[28:18]), 16'h0321);
		chk(16'(rtr_xtd), 16'h0000);
		wait_rtr(1'b0);
		rtr_wait <= 8'hc8;
		xfer(16'h0084, 5);
		wait_rtr(1'b1);
		core.frame({11'h321, 18'h0}, d3);
		repeat (3) @(posedge clk);
		chk(16'(rtr_req), 16'h0000);
		// masked group, then extended-only
		cfg(7, 16'h9000, 16'h1fc0, 16'h1488);
		core.frame({11'h40a, 18'h0}, d3);
		rd(A_PND1, 16'h0040);
		xfer(16'h007f, 7);
		rd(A_ARB2, 16'h9028);
		cfg(7, 16'h9000, 16'h9fc0, 16'h1488);
		core.frame({11'h40a, 18'h0}, d3);
		rd(A_PND1, 16'h0000);
		rd(A_PND2, 16'h0000);
		// extended frame passes the extended-only mask
		core.frame({11'h40a, 18'h00003}, d3, 1'b1);
		rd(A_PND1, 16'h0040);
		xfer(16'h007f, 7);
		rd(A_ARB1, 16'h0003);
		// reset in mid-run clears pending objects
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(A_PND1, 16'h0000);
		rd(A_INT, 16'h0000);
		repeat (3) @(posedge clk);
		conclude();
	end
endmodule // test_crxo_top
`default_nettype wire
